// [ebm_pkg.sv]
// Purpose: Constants and types for the external bus and mode control block
// Assumes: 40 MHz system clock, 16-bit address bus, 8-bit data bus
// Notes: Mode encodings follow the two mode pins, high bit first
package ebm_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam logic [7:0] IO_PAGE_HI = 8'hff;
    localparam logic [1:0] MODE_EXP_NOROM = 2'h1;
    localparam logic [1:0] MODE_EXP_ROM = 2'h2;
    localparam logic [1:0] MODE_SINGLE = 2'h3;
    localparam logic [1:0] MODE_RESET_VAL = 2'h3;
    localparam int SYNC_STAGES = 3;

    typedef enum logic [1:0] {
        EBM_IDLE = 2'b00,
        EBM_ADDR = 2'b01,
        EBM_DATA = 2'b10,
        EBM_WAIT = 2'b11
    } ebm_state_t;
endpackage

// [ebm_sync.sv]
// Purpose: Three-stage synchroniser with agreement filter for pin inputs
// Assumes: Input is asynchronous to clk_i
// Notes: Output changes only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module ebm_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Data
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] q;
    logic [WIDTH-1:0] next_q;

    // Zero width would leave nothing to synchronise
    if (WIDTH < 1) begin : g_width_check
        $error("ebm_sync needs WIDTH of at least 1");
    end

    always_comb begin
        next_q = q;
        for (int i = 0; i < WIDTH; i++) begin
            if (s2[i] == s3[i]) begin
                next_q[i] = s3[i];
            end
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s1 <= RESET_VAL;
            s2 <= RESET_VAL;
            s3 <= RESET_VAL;
            q <= RESET_VAL;
        end else begin
            s1 <= d_i;
            s2 <= s1;
            s3 <= s2;
            q <= next_q;
        end
    end

    assign q_o = q;
endmodule
`default_nettype wire

// [ebm_bus_ctrl.sv]
// Purpose: External bus cycle sequencer and operating mode latch
// Assumes: Core issues one request at a time and holds it until done_o
// Notes: Each bus cycle takes an address state, a data state and any waits
`timescale 1ns/1ps
`default_nettype none
module ebm_bus_ctrl
    import ebm_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rstn_i,
    // Mode pins
    input wire logic boot_mode_pin_hi_i,
    input wire logic boot_mode_pin_lo_i,
    // Core request
    input wire logic req_i,
    input wire logic we_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] wdata_i,
    output logic done_o,
    output logic [DATA_W-1:0] rdata_o,
    // External bus
    output logic [ADDR_W-1:0] addr_o,
    input wire logic [DATA_W-1:0] data_i,
    output logic [DATA_W-1:0] data_o,
    output logic data_oe_o,
    output logic read_strobe_n_o,
    output logic store_strobe_n_o,
    output logic address_strobe_n_o,
    output logic io_page_select_n_o,
    input wire logic wait_n_i,
    // Mode status
    output logic [1:0] boot_mode_latch_reg_o,
    output logic expanded_o,
    output logic rom_enable_o
);
    function automatic logic in_io_page(input logic [ADDR_W-1:0] a);
        return a[ADDR_W-1 -: 8] == IO_PAGE_HI;
    endfunction

    logic wait_n_s;
    logic [1:0] mode_s;

    ebm_sync #(.WIDTH(1), .RESET_VAL(1'b1)) u_wait_sync (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .d_i(wait_n_i),
        .q_o(wait_n_s)
    );

    ebm_sync #(.WIDTH(2), .RESET_VAL(MODE_RESET_VAL)) u_mode_sync (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .d_i({boot_mode_pin_hi_i, boot_mode_pin_lo_i}),
        .q_o(mode_s)
    );

    // Mode latch: captured once after reset release, pins then ignored
    logic [1:0] mode;
    logic [1:0] next_mode;
    logic [2:0] cap_cnt;
    logic [2:0] next_cap_cnt;
    logic mode_valid;
    logic next_mode_valid;
    logic expanded;
    logic next_expanded;
    logic rom_en;
    logic next_rom_en;

    always_comb begin
        next_mode = mode;
        next_cap_cnt = cap_cnt;
        next_mode_valid = mode_valid;
        next_expanded = expanded;
        next_rom_en = rom_en;
        if (!mode_valid) begin
            // Wait until synchroniser holds post-reset pin levels
            next_cap_cnt = cap_cnt + 3'h1;
            if (cap_cnt == 3'(SYNC_STAGES + 1)) begin
                next_mode = mode_s;
                next_mode_valid = 1'b1;
                unique case (mode_s)
                    MODE_EXP_NOROM: begin
                        next_expanded = 1'b1;
                        next_rom_en = 1'b0;
                    end
                    MODE_EXP_ROM: begin
                        next_expanded = 1'b1;
                        next_rom_en = 1'b1;
                    end
                    default: begin
                        // Single-chip, and reserved code 00 treated likewise
                        next_expanded = 1'b0;
                        next_rom_en = 1'b1;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            mode <= MODE_RESET_VAL;
            cap_cnt <= 3'h0;
            mode_valid <= 1'b0;
            expanded <= 1'b0;
            rom_en <= 1'b1;
        end else begin
            mode <= next_mode;
            cap_cnt <= next_cap_cnt;
            mode_valid <= next_mode_valid;
            expanded <= next_expanded;
            rom_en <= next_rom_en;
        end
    end

    // Bus sequencer
    ebm_state_t state;
    ebm_state_t next_state;
    logic [ADDR_W-1:0] addr_q;
    logic [ADDR_W-1:0] next_addr_q;
    logic [DATA_W-1:0] wdata_q;
    logic [DATA_W-1:0] next_wdata_q;
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] next_rdata_q;
    logic we_q;
    logic next_we_q;
    logic as_n;
    logic next_as_n;
    logic rd_n;
    logic next_rd_n;
    logic wr_n;
    logic next_wr_n;
    logic ios_n;
    logic next_ios_n;
    logic oe;
    logic next_oe;
    logic done;
    logic next_done;

    always_comb begin
        next_state = state;
        next_addr_q = addr_q;
        next_wdata_q = wdata_q;
        next_rdata_q = rdata_q;
        next_we_q = we_q;
        next_as_n = 1'b1;
        next_rd_n = 1'b1;
        next_wr_n = 1'b1;
        next_ios_n = 1'b1;
        next_oe = 1'b0;
        next_done = 1'b0;
        unique case (state)
            EBM_IDLE: begin
                // Requests only served once mode is known and expanded
                if (req_i && mode_valid && expanded && !done) begin
                    next_state = EBM_ADDR;
                    next_addr_q = addr_i;
                    next_wdata_q = wdata_i;
                    next_we_q = we_i;
                    next_as_n = 1'b0;
                    next_ios_n = !in_io_page(addr_i);
                end
            end
            EBM_ADDR: begin
                next_state = EBM_DATA;
                next_as_n = 1'b0;
                next_ios_n = !in_io_page(addr_q);
                next_rd_n = we_q;
                next_wr_n = !we_q;
                next_oe = we_q;
            end
            EBM_DATA, EBM_WAIT: begin
                if (!wait_n_s) begin
                    // Stretch the cycle, strobes held
                    next_state = EBM_WAIT;
                    next_as_n = 1'b0;
                    next_ios_n = ios_n;
                    next_rd_n = rd_n;
                    next_wr_n = wr_n;
                    next_oe = oe;
                end else begin
                    next_state = EBM_IDLE;
                    next_rdata_q = we_q ? rdata_q : data_i;
                    next_done = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state <= EBM_IDLE;
            addr_q <= '0;
            wdata_q <= '0;
            rdata_q <= '0;
            we_q <= 1'b0;
            as_n <= 1'b1;
            rd_n <= 1'b1;
            wr_n <= 1'b1;
            ios_n <= 1'b1;
            oe <= 1'b0;
            done <= 1'b0;
        end else begin
            state <= next_state;
            addr_q <= next_addr_q;
            wdata_q <= next_wdata_q;
            rdata_q <= next_rdata_q;
            we_q <= next_we_q;
            as_n <= next_as_n;
            rd_n <= next_rd_n;
            wr_n <= next_wr_n;
            ios_n <= next_ios_n;
            oe <= next_oe;
            done <= next_done;
        end
    end

    assign addr_o = addr_q;
    assign data_o = wdata_q;
    assign data_oe_o = oe;
    assign read_strobe_n_o = rd_n;
    assign store_strobe_n_o = wr_n;
    assign address_strobe_n_o = as_n;
    assign io_page_select_n_o = ios_n;
    assign done_o = done;
    assign rdata_o = rdata_q;
    assign boot_mode_latch_reg_o = mode;
    assign expanded_o = expanded;
    assign rom_enable_o = rom_en;

    chk_wait_holds: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (state == EBM_DATA && !wait_n_s) |=> (state == EBM_WAIT && !as_n))
        else $error("wait request did not stretch the cycle");
    chk_read_strobe: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !rd_n |-> (!as_n && !we_q && wr_n && !oe))
        else $error("read strobe outside external read");
    chk_store_strobe: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !wr_n |-> (!as_n && we_q && oe))
        else $error("store strobe outside external write");
    chk_addr_strobe: assert property (@(posedge clk_i) disable iff (!rstn_i)
        $fell(as_n) |-> ##1 (!as_n && $stable(addr_q)))
        else $error("address strobe without stable address");
    chk_io_page: assert property (@(posedge clk_i) disable iff (!rstn_i)
        !as_n |-> (ios_n == !in_io_page(addr_q)))
        else $error("page select mismatch with address");
    chk_mode_decode: assert property (@(posedge clk_i) disable iff (!rstn_i)
        mode_valid |-> (expanded == (mode == MODE_EXP_NOROM || mode == MODE_EXP_ROM)))
        else $error("mode decode wrong");
    chk_mode_latch: assert property (@(posedge clk_i) disable iff (!rstn_i)
        $rose(mode_valid) |-> (mode == $past(mode_s)))
        else $error("mode not captured from pins");
    chk_mode_stable: assert property (@(posedge clk_i) disable iff (!rstn_i)
        $past(mode_valid) |-> $stable(mode))
        else $error("mode changed after capture");
    chk_addr_out: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (state == EBM_IDLE && next_state == EBM_ADDR) |=> (addr_o == $past(addr_i)))
        else $error("address not driven");
    chk_idle_strobes: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (state == EBM_IDLE && $past(state) == EBM_IDLE) |-> (as_n && rd_n && wr_n && ios_n))
        else $error("strobe active while idle");
    chk_wait_release: assert property (@(posedge clk_i) disable iff (!rstn_i)
        (state == EBM_WAIT && wait_n_s) |=> (state == EBM_IDLE && done ##1 as_n))
        else $error("cycle did not end on wait release");
endmodule
`default_nettype wire

// [ebm_ext_dev.sv]
// Purpose: Behavioural external memory and peripheral on the expansion bus
// Assumes: Same clock as the bus controller, bus pins seen directly
// Notes: Wait request stays low until hold_i strobe cycles have passed
`timescale 1ns/1ps
`default_nettype none
module ebm_ext_dev
    import ebm_pkg::*;
(
    // Clock
    input wire logic clk_i,
    // Bus from the controller
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic [DATA_W-1:0] data_i,
    input wire logic data_oe_i,
    input wire logic read_strobe_n_i,
    input wire logic store_strobe_n_i,
    input wire logic io_page_select_n_i,
    // Answers and observation
    input wire logic [3:0] hold_i,
    output logic [DATA_W-1:0] data_o,
    output logic wait_n_o,
    output var logic [DATA_W-1:0] last_wdata_o,
    output var logic periph_hit_o
);
    logic [3:0] cnt;
    logic [DATA_W-1:0] last;
    wire periph_sel;

    initial begin
        cnt = 4'h0;
        last = 8'h00;
        last_wdata_o = 8'h00;
        periph_hit_o = 1'b0;
    end

    // Page select stands in for the upper address byte
    assign periph_sel = !io_page_select_n_i && (addr_i[7:4] == 4'h8 || addr_i[7:3] == 5'h15);
    // Released bus toggles so a stale value never looks valid
    assign data_o = !read_strobe_n_i ? (addr_i[7:0] ^ 8'h5a) : ~last;
    assign wait_n_o = !(hold_i > cnt);

    always @(posedge clk_i) begin
        last <= data_o;
        if (!read_strobe_n_i || !store_strobe_n_i) begin
            cnt <= (cnt == 4'hf) ? cnt : cnt + 4'h1;
        end else begin
            cnt <= 4'h0;
        end
        if (!store_strobe_n_i && data_oe_i) begin
            last_wdata_o <= data_i;
            periph_hit_o <= periph_sel;
        end
    end
endmodule
`default_nettype wire

// [tb_ebm_bus_ctrl.sv]
// Purpose: Self-checking bench for the bus sequencer and mode latch
// Assumes: Inputs change 1 ns after the rising clock edge
// Notes: Wait is raised early because the wait input is synchronised
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; $display("unexpected %s exp=%h got=%h", nm, e, g); end end
module tb_ebm_bus_ctrl;
    import ebm_pkg::*;
    logic clk = 1'b0, rstn_i = 1'b0, pin_hi = 1'b0, pin_lo = 1'b1, req = 1'b0, we = 1'b0;
    logic [15:0] addr = 16'h0000, addr_o;
    logic [7:0] wdata = 8'h00, rdata, bus_out, bus_in, last_wdata;
    logic [3:0] hold = 4'h0;
    logic done, oe, rd_n, wr_n, as_n, ios_n, wait_n, expanded, rom_en, hit;
    logic [1:0] latch;
    int n_fail = 0, n_tests = 0;

    always #12.5 clk = ~clk;

    ebm_bus_ctrl i_ebm_bus_ctrl (.clk_i(clk), .rstn_i(rstn_i), .boot_mode_pin_hi_i(pin_hi),
        .boot_mode_pin_lo_i(pin_lo), .req_i(req), .we_i(we), .addr_i(addr), .wdata_i(wdata),
        .done_o(done), .rdata_o(rdata), .addr_o(addr_o), .data_i(bus_in), .data_o(bus_out),
        .data_oe_o(oe), .read_strobe_n_o(rd_n), .store_strobe_n_o(wr_n), .address_strobe_n_o(as_n),
        .io_page_select_n_o(ios_n), .wait_n_i(wait_n), .boot_mode_latch_reg_o(latch),
        .expanded_o(expanded), .rom_enable_o(rom_en));

    ebm_ext_dev i_ebm_ext_dev (.clk_i(clk), .addr_i(addr_o), .data_i(bus_out), .data_oe_i(oe),
        .read_strobe_n_i(rd_n), .store_strobe_n_i(wr_n), .io_page_select_n_i(ios_n), .hold_i(hold),
        .data_o(bus_in), .wait_n_o(wait_n), .last_wdata_o(last_wdata), .periph_hit_o(hit));

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic boot(input logic [1:0] m, input logic x, input logic r);
        rstn_i = 1'b0;
        {pin_hi, pin_lo} = m;
        repeat (2) @(posedge clk);
        #1;
        `CHK("strobes in reset", 4'hf, {rd_n, wr_n, as_n, ios_n})
        `CHK("latch in reset", MODE_RESET_VAL, latch)
        rstn_i = 1'b1;
        repeat (10) @(posedge clk);
        #1;
        `CHK("mode latch", m, latch)
        `CHK("expanded", x, expanded)
        `CHK("rom enable", r, rom_en)
    endtask

    task automatic xfer(input logic w, input logic [15:0] a, input logic [7:0] wd, input logic [3:0] h);
        int rd_lo, wr_lo, n;
        logic as_ok, a_ok, ios_ok, oe_ok;
        rd_lo = 0;
        wr_lo = 0;
        n = 0;
        as_ok = 1'b1;
        a_ok = 1'b1;
        ios_ok = 1'b1;
        oe_ok = 1'b1;
        hold = h;
        // Synchroniser latency: wait must be low well before the data state ends
        if (h != 4'h0) repeat (5) @(posedge clk);
        if (h != 4'h0) #1;
        req = 1'b1;
        we = w;
        addr = a;
        wdata = wd;
        do begin
            @(posedge clk);
            #1;
            n++;
            if (!rd_n || !wr_n) begin
                rd_lo += int'(!rd_n);
                wr_lo += int'(!wr_n);
                as_ok &= (as_n === 1'b0);
                a_ok &= (addr_o === a);
                ios_ok &= (ios_n === (a[15:8] != IO_PAGE_HI));
                oe_ok &= (oe === w);
            end
        end while (done !== 1'b1 && n < 60);
        req = 1'b0;
        hold = 4'h0;
        if (n >= 60) begin
            n_fail++;
            $display("unexpected done_o exp=1 got=%h", done);
            give_verdict();
        end else begin
            `CHK("unused strobe cycles", 0, w ? rd_lo : wr_lo)
            if (h == 4'h0) `CHK("strobe cycles", 1, w ? wr_lo : rd_lo)
            if (h != 4'h0) `CHK("stretched cycle", 1'b1, (rd_lo + wr_lo > h) && (rd_lo + wr_lo < h + 8))
            `CHK("address strobe", 1'b1, as_ok)
            `CHK("address lines", 1'b1, a_ok)
            `CHK("page select", 1'b1, ios_ok)
            `CHK("data enable", 1'b1, oe_ok)
            if (!w) `CHK("read data", a[7:0] ^ 8'h5a, rdata)
            if (w) `CHK("written data", wd, last_wdata)
            if (w) `CHK("peripheral select", (a[15:4] == 12'hff8 || a[15:3] == 13'h1ff5), hit)
            @(posedge clk);
            #1;
            `CHK("idle strobes", 4'hf, {rd_n, wr_n, as_n, ios_n})
        end
    endtask

    task automatic refused();
        int seen;
        seen = 0;
        req = 1'b1;
        we = 1'b0;
        addr = 16'h2000;
        repeat (30) begin
            @(posedge clk);
            #1;
            seen += int'(done !== 1'b0 || {rd_n, wr_n, as_n, ios_n} !== 4'hf);
        end
        req = 1'b0;
        `CHK("single-chip bus activity", 0, seen)
    endtask

    initial begin
        #1;
        boot(2'h1, 1'b1, 1'b0);
        xfer(1'b0, 16'h1234, 8'h00, 4'h0);
        xfer(1'b1, 16'hff85, 8'ha5, 4'h0);
        xfer(1'b0, 16'hffaa, 8'h00, 4'h0);
        xfer(1'b1, 16'hffab, 8'h5c, 4'h0);
        xfer(1'b0, 16'h0010, 8'h00, 4'h3);
        xfer(1'b1, 16'h4000, 8'h3c, 4'h5);
        boot(2'h2, 1'b1, 1'b1);
        xfer(1'b0, 16'hff00, 8'h00, 4'h0);
        xfer(1'b0, 16'hfeff, 8'h00, 4'h0);
        boot(2'h3, 1'b0, 1'b1);
        refused();
        // Undefined pin code 00 behaves as single-chip
        boot(2'h0, 1'b0, 1'b1);
        refused();
        give_verdict();
    end
endmodule
`default_nettype wire
